// ---- core/psr_energy_timer.sv ----
`default_nettype none
module psr_energy_timer #(
  parameter int unsigned TIMEOUT_CYC = psr_pkg::ENERGY_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Line energy seen, one-cycle pulse
  input wire logic energy_seen,
  // Energy detected level
  output logic energy_detected
);
  import psr_pkg::*;

  localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYC - 1);

  logic [CW-1:0] count_q, count_d;
  logic det_q, det_d;

  // Quiet-time counter; drops the level after the timeout
  always_comb begin
    count_d = count_q;
    det_d = det_q;
    if (energy_seen) begin
      count_d = '0;
      det_d = 1'b1;
    end else if (det_q) begin
      if (count_q == LAST) begin
        det_d = 1'b0;
        count_d = '0;
      end else begin
        count_d = count_q + CW'(1);
      end
    end
  end

  // Hardware reset sets the level; soft reset is not seen here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
      det_q <= 1'b1;
    end else begin
      count_q <= count_d;
      det_q <= det_d;
    end
  end

  assign energy_detected = det_q;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ENERGY_ON: assert property (energy_seen |=> det_q)
    else $error("energy level not raised by line energy");
  AST_ENERGY_OFF: assert property (
    det_q && !energy_seen && count_q == LAST |=> !det_q)
    else $error("energy level not dropped at timeout");
endmodule : psr_energy_timer
`default_nettype wire

// ---- core/psr_regs.sv ----
// Notes on behaviour
// - Override clear: strap pin alone decides automatic crossover.
// - Auto enable bit acts only with override set; 0 means manual.
// - Manual mode: state 0 no crossover, state 1 pairs swapped.
// - Reference-lock bit holds 10M receive PLL on reference clock.
// - Read-only receive polarity bit, 1 reversed, resets to 0.
// - Low four bits of control/status ignore writes, read zero.
// - Flags latch on energy, negotiation complete, remote fault.
// - Link-down flag latches while link is negated, also at reset.
// - Flags latch on partner ack, detection fault, page received.
// - Mask bits 7:0 read-write, reset 0, upper bits read zero.
// - Read-only negotiation done bit, resets to 0.
// - Three-bit read-only resolved speed and duplex in bits 4:2.
// - Energy level falls after 256 ms quiet; hardware reset sets it.
`default_nettype none
module psr_regs #(
  parameter int unsigned ENERGY_TIMEOUT = psr_pkg::ENERGY_TIMEOUT_CYC
) (
  // Clock, reset, soft reset pulse
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic soft_reset,
  // AXI4-Lite write address and data
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Strap pin, asynchronous
  input wire logic crossover_strap_pin,
  // Datapath status, same clock
  input wire logic line_energy_seen,
  input wire logic autoneg_done,
  input wire logic remote_fault,
  input wire logic link_up,
  input wire logic partner_ack,
  input wire logic parallel_detect_fault,
  input wire logic page_received,
  input wire logic rx_polarity_reversed,
  input wire logic [2:0] resolved_speed_duplex,
  // Control toward the datapath
  output logic mdix_auto_en,
  output logic mdix_crossover,
  output logic rx_pll_reference_lock,
  // Interrupt request
  output logic irq
);
  import psr_pkg::*;

  // Bus state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d;
  logic [1:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic aw_fire, w_fire, ar_fire, do_write, wr_hit, rd_hit;
  logic [31:0] rd_word;

  // Register state
  logic [15:5] scs_q, scs_d;
  logic [7:0] flags_q, flags_d, mask_q, mask_d, flag_set, flag_clr;
  logic [6:0] pss_rsvd_q, pss_rsvd_d;
  logic pol_q, done_q, done_prev_q, energy_prev_q;
  logic [2:0] spd_q;
  logic [15:0] scs_m, mask_m, pss_m;
  logic energy_detected;

  // Strap synchroniser and outputs
  logic strap_s1_q, strap_s2_q;
  logic auto_q, auto_d, xover_q, xover_d, lock_q, irq_q, irq_d;

  psr_energy_timer #(
    .TIMEOUT_CYC(ENERGY_TIMEOUT)
  ) u_energy (
    .aclk(aclk),
    .aresetn(aresetn),
    .energy_seen(line_energy_seen),
    .energy_detected(energy_detected)
  );

  // Handshakes and decode
  assign aw_fire = awvalid && awready_q;
  assign w_fire = wvalid && wready_q;
  assign ar_fire = arvalid && arready_q;
  assign do_write = aw_have_q && w_have_q;
  assign wr_hit = psr_hit(awaddr_q, IDX_SCS) ||
    psr_hit(awaddr_q, IDX_FLAGS) || psr_hit(awaddr_q, IDX_MASK) ||
    psr_hit(awaddr_q, IDX_PSS);
  assign rd_hit = psr_hit(araddr, IDX_SCS) ||
    psr_hit(araddr, IDX_FLAGS) || psr_hit(araddr, IDX_MASK) ||
    psr_hit(araddr, IDX_PSS);

  // Read data mux; low nibble and reserved tops read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (psr_hit(araddr, IDX_SCS)) begin
      rd_word[15:0] = {scs_q, pol_q, 4'h0};
    end else if (psr_hit(araddr, IDX_FLAGS)) begin
      rd_word[7:0] = flags_q;
    end else if (psr_hit(araddr, IDX_MASK)) begin
      rd_word[7:0] = mask_q;
    end else if (psr_hit(araddr, IDX_PSS)) begin
      rd_word[15:0] = {3'h0, done_q, pss_rsvd_q, spd_q, 2'h0};
    end
  end

  // AXI channel next state
  always_comb begin
    aw_have_d = aw_have_q || aw_fire;
    w_have_d = w_have_q || w_fire;
    awaddr_d = aw_fire ? awaddr : awaddr_q;
    wdata_d = w_fire ? wdata : wdata_q;
    wstrb_d = w_fire ? wstrb[1:0] : wstrb_q;
    bvalid_d = bvalid_q && !bready;
    bresp_d = bresp_q;
    if (do_write) begin
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? RESP_OKAY : RESP_DECERR;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    rvalid_d = rvalid_q && !rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_fire) begin
      rvalid_d = 1'b1;
      rdata_d = rd_word;
      rresp_d = rd_hit ? RESP_OKAY : RESP_DECERR;
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 2'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Flag sources; link-down is a level so it re-latches after a clear
  assign flag_set = {energy_detected && !energy_prev_q,
    done_q && !done_prev_q, remote_fault, !link_up,
    partner_ack, parallel_detect_fault, page_received, 1'b0};

  // Register file next state
  always_comb begin
    scs_m = psr_merge({scs_q, 5'h00}, wdata_q[15:0], wstrb_q,
      SCS_RW_MASK);
    mask_m = psr_merge({8'h00, mask_q}, wdata_q[15:0], wstrb_q,
      MASK_RW_MASK);
    pss_m = psr_merge({4'h0, pss_rsvd_q, 5'h00}, wdata_q[15:0], wstrb_q,
      PSS_RW_MASK);
    scs_d = scs_q;
    mask_d = mask_q;
    pss_rsvd_d = pss_rsvd_q;
    flag_clr = 8'h00;
    if (ar_fire && psr_hit(araddr, IDX_FLAGS)) begin
      flag_clr = 8'hff;
    end
    if (do_write) begin
      if (psr_hit(awaddr_q, IDX_SCS)) begin
        scs_d = scs_m[15:5];
      end
      if (psr_hit(awaddr_q, IDX_MASK)) begin
        mask_d = mask_m[7:0];
      end
      if (psr_hit(awaddr_q, IDX_PSS)) begin
        pss_rsvd_d = pss_m[11:5];
      end
      if (psr_hit(awaddr_q, IDX_FLAGS) && wstrb_q[0]) begin
        flag_clr = flag_clr | wdata_q[7:0];
      end
    end
    // Set wins over a clear in the same cycle
    flags_d = (flags_q & ~flag_clr) | flag_set;
    if (soft_reset) begin
      scs_d = {SCS_RST[15:11], scs_q[SCS_PLL_LOCK_BIT], SCS_RST[9:5]};
      mask_d = MASK_RST;
      pss_rsvd_d = PSS_RSVD_RST;
      flags_d = flag_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scs_q <= SCS_RST[15:5];
      mask_q <= MASK_RST;
      pss_rsvd_q <= PSS_RSVD_RST;
      flags_q <= 8'h00;
      pol_q <= 1'b0;
      done_q <= 1'b0;
      done_prev_q <= 1'b0;
      energy_prev_q <= 1'b1;
      spd_q <= 3'h0;
    end else begin
      scs_q <= scs_d;
      mask_q <= mask_d;
      pss_rsvd_q <= pss_rsvd_d;
      flags_q <= flags_d;
      pol_q <= rx_polarity_reversed;
      done_q <= autoneg_done;
      done_prev_q <= done_q;
      energy_prev_q <= energy_detected;
      spd_q <= resolved_speed_duplex;
    end
  end

  // Crossover resolution and interrupt
  always_comb begin
    if (!scs_q[SCS_OVERRIDE_BIT]) begin
      auto_d = strap_s2_q;
      xover_d = 1'b0;
    end else begin
      auto_d = scs_q[SCS_AUTO_EN_BIT];
      xover_d = !scs_q[SCS_AUTO_EN_BIT] &&
        scs_q[SCS_STATE_BIT];
    end
    irq_d = |(flags_q & mask_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
      auto_q <= 1'b0;
      xover_q <= 1'b0;
      lock_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      strap_s1_q <= crossover_strap_pin;
      strap_s2_q <= strap_s1_q;
      auto_q <= auto_d;
      xover_q <= xover_d;
      lock_q <= scs_q[SCS_PLL_LOCK_BIT];
      irq_q <= irq_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign mdix_auto_en = auto_q;
  assign mdix_crossover = xover_q;
  assign rx_pll_reference_lock = lock_q;
  assign irq = irq_q;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_scs_write;
    do_write && psr_hit(awaddr_q, IDX_SCS) && wstrb_q[1];
  endsequence
  sequence s_rd(logic [7:0] idx);
    ar_fire && psr_hit(araddr, idx);
  endsequence

  AST_STRAP: assert property (!scs_q[SCS_OVERRIDE_BIT] |=>
    mdix_auto_en == $past(strap_s2_q) && !mdix_crossover)
    else $error("strap not followed without override");
  AST_AUTO_EN: assert property (scs_q[SCS_OVERRIDE_BIT] |=>
    mdix_auto_en == $past(scs_q[SCS_AUTO_EN_BIT]))
    else $error("auto enable not applied under override");
  AST_MANUAL: assert property (scs_q[SCS_OVERRIDE_BIT] &&
    !scs_q[SCS_AUTO_EN_BIT] |=>
    mdix_crossover == $past(scs_q[SCS_STATE_BIT]))
    else $error("manual crossover state wrong");
  AST_PLL_LOCK: assert property (s_scs_write ##0 !soft_reset |=>
    ##1 rx_pll_reference_lock == $past(wdata_q[SCS_PLL_LOCK_BIT], 2))
    else $error("reference lock not applied after write");
  AST_SCS_READ: assert property (s_rd(IDX_SCS) |=>
    rvalid && rdata[3:0] == 4'h0 && rdata[4] == $past(pol_q))
    else $error("control/status read wrong");
  AST_REM_FAULT: assert property (remote_fault |=>
    flags_q[FLG_REM_FAULT])
    else $error("remote fault flag not latched");
  // Release edge still loads reset flags, so start one cycle later
  AST_LINK_DOWN: assert property (aresetn && !link_up |=>
    flags_q[FLG_LINK_DOWN])
    else $error("link down flag not latched");
  AST_MASK_READ: assert property (s_rd(IDX_MASK) |=>
    rdata[31:8] == 24'h00_0000 && rdata[7:0] == $past(mask_q))
    else $error("mask read wrong");
  AST_PSS_READ: assert property (s_rd(IDX_PSS) |=>
    rdata[PSS_DONE_BIT] == $past(done_q) &&
    rdata[4:2] == $past(spd_q))
    else $error("special status read wrong");
  AST_CLR_ON_READ: assert property (s_rd(IDX_FLAGS) ##0
    flag_set == 8'h00 |=> flags_q == 8'h00)
    else $error("flags not cleared by read");
  AST_IRQ: assert property (|(flags_q & mask_q) |=> ##[0:1] irq)
    else $error("interrupt not raised");
  AST_IRQ_LOW: assert property (!(|(flags_q & mask_q)) |=> !irq)
    else $error("interrupt without enabled flag");
endmodule : psr_regs
`default_nettype wire

// ---- shared/psr_pkg.sv ----
`default_nettype none
package psr_pkg;
  // Clock and energy timeout
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned ENERGY_TIMEOUT_MS = 256;
  localparam int unsigned ENERGY_TIMEOUT_CYC =
    CLK_HZ / 1000 * ENERGY_TIMEOUT_MS;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SCS = 8'h1b;
  localparam logic [7:0] IDX_FLAGS = 8'h1d;
  localparam logic [7:0] IDX_MASK = 8'h1e;
  localparam logic [7:0] IDX_PSS = 8'h1f;

  // Special control/status fields
  localparam int unsigned SCS_OVERRIDE_BIT = 15;
  localparam int unsigned SCS_AUTO_EN_BIT = 14;
  localparam int unsigned SCS_STATE_BIT = 13;
  localparam int unsigned SCS_PLL_LOCK_BIT = 10;
  localparam int unsigned SCS_POL_BIT = 4;
  localparam logic [15:0] SCS_RW_MASK = 16'hffe0;
  localparam logic [15:0] SCS_RST = 16'h0000;

  // Interrupt flag positions
  localparam int unsigned FLG_ENERGY = 7;
  localparam int unsigned FLG_AN_DONE = 6;
  localparam int unsigned FLG_REM_FAULT = 5;
  localparam int unsigned FLG_LINK_DOWN = 4;
  localparam int unsigned FLG_PARTNER_ACK = 3;
  localparam int unsigned FLG_PD_FAULT = 2;
  localparam int unsigned FLG_PAGE_RX = 1;
  localparam logic [15:0] MASK_RW_MASK = 16'h00ff;
  localparam logic [7:0] MASK_RST = 8'h00;

  // PHY special status fields
  localparam int unsigned PSS_DONE_BIT = 12;
  localparam int unsigned PSS_SPEED_LSB = 2;
  localparam logic [15:0] PSS_RW_MASK = 16'h0fe0;
  localparam logic [6:0] PSS_RSVD_RST = 7'h02;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Word address match against a register index
  function automatic logic psr_hit(logic [31:0] a, logic [7:0] idx);
    return a[31:2] == {22'h0, idx};
  endfunction : psr_hit

  // Byte-lane write merge limited to writable bits
  function automatic logic [15:0] psr_merge(logic [15:0] old,
      logic [15:0] wd, logic [1:0] strb, logic [15:0] rw);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & rw;
    return (old & ~lanes) | (wd & lanes);
  endfunction : psr_merge
endpackage : psr_pkg
`default_nettype wire

// ---- verif/phy_special_ctrl_irq_regs_tb.sv ----
`default_nettype none
module phy_special_ctrl_irq_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import psr_pkg::*;

  localparam logic [7:0] IDX_NONE = 8'h1c;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, soft_rst = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic energy, rfault, ack, pdf, page, link, an, pol, strap;
  logic [2:0] spd_code;
  logic mdix_auto_en, mdix_crossover, rx_pll_reference_lock, irq;
  int n_errors = 0;
  int num_checks = 0;
  logic [5:0] xt [7] = '{6'h00, 6'h06, 6'h0e, 6'h10, 6'h24, 6'h2d, 6'h32};
  int ev [5] = '{7, 5, 3, 2, 1};
  logic [2:0] spd [4] = '{3'h1, 3'h5, 3'h2, 3'h6};

  // Clock, 100 ns period
  initial begin
    forever #50 aclk = ~aclk;
  end

  // Datapath stand-in
  psr_phy_model phy (.aclk(aclk), .line_energy_seen(energy),
    .remote_fault(rfault), .partner_ack(ack),
    .parallel_detect_fault(pdf), .page_received(page), .link_up(link),
    .autoneg_done(an), .rx_polarity_reversed(pol),
    .crossover_strap_pin(strap), .resolved_speed_duplex(spd_code));

  psr_regs #(.ENERGY_TIMEOUT(20)) uut (.aclk(aclk), .aresetn(aresetn),
    .soft_reset(soft_rst), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'h3), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .crossover_strap_pin(strap),
    .line_energy_seen(energy), .autoneg_done(an), .remote_fault(rfault),
    .link_up(link), .partner_ack(ack), .parallel_detect_fault(pdf),
    .page_received(page), .rx_polarity_reversed(pol),
    .resolved_speed_duplex(spd_code), .mdix_auto_en(mdix_auto_en),
    .mdix_crossover(mdix_crossover),
    .rx_pll_reference_lock(rx_pll_reference_lock), .irq(irq));

  // Word compare, counted
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  // Single output bit compare
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  // Bus write, both channels offered together, response checked
  task automatic wr(input logic [7:0] idx, input logic [15:0] d,
      input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {22'h0, idx, 2'h0};
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (((awvalid && !awready) || (wvalid && !wready)) && n < 50);
    do @(posedge aclk); while (!bvalid && ++n < 100);
    bready <= 1'b0;
    chk_word({30'h0, bresp}, {30'h0, er});
  endtask : wr

  // Bus read, data and response checked
  task automatic rd(input logic [7:0] idx, input logic [15:0] e,
      input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {22'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready && ++n < 50);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid && ++n < 100);
    rready <= 1'b0;
    chk_word({30'h0, rresp}, {30'h0, er});
    chk_word(rdata, {16'h0, e});
  endtask : rd

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    end_sim();
  end

  // Test sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    rd(IDX_FLAGS, 16'h0010, RESP_OKAY);
    phy.lines({3'h4, 1'b0, 3'h1});
    rd(IDX_FLAGS, 16'h0010, RESP_OKAY);
    rd(IDX_FLAGS, 16'h0000, RESP_OKAY);
    rd(IDX_SCS, 16'h0000, RESP_OKAY);
    rd(IDX_MASK, 16'h0000, RESP_OKAY);
    rd(IDX_PSS, 16'h0044, RESP_OKAY);
    $display("test reset done");
    // Crossover: {override, enable, state, strap, auto, swapped}
    foreach (xt[i]) begin
      phy.lines({3'h4, xt[i][2], 3'h1});
      wr(IDX_SCS, {xt[i][5:3], 13'h0}, RESP_OKAY);
      cyc(4);
      chk_bit(mdix_auto_en, xt[i][1]);
      chk_bit(mdix_crossover, xt[i][0]);
    end
    $display("test crossover done");
    wr(IDX_SCS, 16'h040f, RESP_OKAY);
    cyc(3);
    chk_bit(rx_pll_reference_lock, 1'b1);
    phy.lines({3'h5, 1'b0, 3'h1});
    cyc(3);
    rd(IDX_SCS, 16'h0410, RESP_OKAY);
    wr(IDX_SCS, 16'h0000, RESP_OKAY);
    cyc(3);
    chk_bit(rx_pll_reference_lock, 1'b0);
    $display("test lock and polarity done");
    // Only the partner acknowledge source is unmasked
    wr(IDX_MASK, 16'h0008, RESP_OKAY);
    rd(IDX_MASK, 16'h0008, RESP_OKAY);
    foreach (ev[i]) begin
      phy.pulse(ev[i]);
      cyc(3);
      chk_bit(irq, ev[i] == 3);
      rd(IDX_FLAGS, 16'h0001 << ev[i], RESP_OKAY);
      rd(IDX_FLAGS, 16'h0000, RESP_OKAY);
      cyc(2);
      chk_bit(irq, 1'b0);
    end
    $display("test flags done");
    wr(IDX_PSS, 16'h0040, RESP_OKAY);
    foreach (spd[i]) begin
      phy.lines({3'h7, 1'b0, spd[i]});
      cyc(3);
      rd(IDX_PSS, {3'h0, 1'b1, 7'h02, spd[i], 2'h0}, RESP_OKAY);
    end
    rd(IDX_FLAGS, 16'h0040, RESP_OKAY);
    phy.lines({3'h5, 1'b0, 3'h6});
    cyc(3);
    rd(IDX_PSS, 16'h0058, RESP_OKAY);
    $display("test status done");
    wr(IDX_NONE, 16'h00ff, RESP_DECERR);
    rd(IDX_NONE, 16'h0000, RESP_DECERR);
    rd(IDX_MASK, 16'h0008, RESP_OKAY);
    $display("test unmapped done");
    // Soft reset keeps only the lock bit of the control register
    wr(IDX_SCS, 16'hc400, RESP_OKAY);
    cyc(3);
    chk_bit(mdix_auto_en, 1'b1);
    soft_rst <= 1'b1;
    cyc(1);
    soft_rst <= 1'b0;
    cyc(4);
    chk_bit(mdix_auto_en, 1'b0);
    chk_bit(rx_pll_reference_lock, 1'b1);
    rd(IDX_SCS, 16'h0410, RESP_OKAY);
    rd(IDX_MASK, 16'h0000, RESP_OKAY);
    rd(IDX_PSS, 16'h0058, RESP_OKAY);
    $display("test soft reset done");
    end_sim();
  end
endmodule : phy_special_ctrl_irq_regs_tb
`default_nettype wire

// ---- verif/psr_phy_model.sv ----
`default_nettype none
module psr_phy_model (
  // Clock
  input wire logic aclk,
  // Event pulses toward the register block
  output var logic line_energy_seen,
  output var logic remote_fault,
  output var logic partner_ack,
  output var logic parallel_detect_fault,
  output var logic page_received,
  // Line levels
  output var logic link_up,
  output var logic autoneg_done,
  output var logic rx_polarity_reversed,
  output var logic crossover_strap_pin,
  output var logic [2:0] resolved_speed_duplex
);
  timeunit 1ns;
  timeprecision 1ns;

  // Line starts down, nothing pending
  initial begin
    {line_energy_seen, remote_fault, partner_ack} = 3'h0;
    {parallel_detect_fault, page_received} = 2'h0;
    {link_up, autoneg_done, rx_polarity_reversed} = 3'h0;
    crossover_strap_pin = 1'b0;
    resolved_speed_duplex = 3'h1;
  end

  // One-cycle pulse on the source of the given flag bit
  task automatic pulse(input int b);
    @(posedge aclk);
    case (b)
      7: line_energy_seen <= 1'b1;
      5: remote_fault <= 1'b1;
      3: partner_ack <= 1'b1;
      2: parallel_detect_fault <= 1'b1;
      default: page_received <= 1'b1;
    endcase
    @(posedge aclk);
    {line_energy_seen, remote_fault, partner_ack} <= 3'h0;
    {parallel_detect_fault, page_received} <= 2'h0;
  endtask : pulse

  // Link, negotiation, polarity, strap, speed code
  task automatic lines(input logic [6:0] v);
    @(posedge aclk);
    {link_up, autoneg_done, rx_polarity_reversed} <= v[6:4];
    crossover_strap_pin <= v[3];
    resolved_speed_duplex <= v[2:0];
  endtask : lines
endmodule : psr_phy_model
`default_nettype wire
